// file: common/dcit_pkg.sv
// package for the down counting interval timer: register map, field layout, reset values
// assumes a 32-bit avalon-mm slave port on the 10 MHz main clock
package dcit_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [3:0] DCIT_OFS_COUNT = 4'h0; // timer_count_value, read only
  localparam logic [3:0] DCIT_OFS_PERIOD = 4'h4; // timer_period_value
  localparam logic [3:0] DCIT_OFS_CTRL = 4'h8; // timer_control_register
  localparam logic [3:0] DCIT_OFS_PRESCALE = 4'hc; // tick_prescale_counter divide value
  // ==========================================================================
  // control register fields
  localparam int DCIT_CTRL_RUN_BIT = 0;
  localparam int DCIT_CTRL_RELOAD_BIT = 1; // counter_reload_request, self clearing
  localparam int DCIT_CTRL_SRC_LSB = 4; // two bit source select
  localparam int DCIT_CTRL_OVF_BIT = 8; // overflow flag, write one to clear
  localparam int DCIT_CTRL_MASK_BIT = 9; // interrupt mask, one enables
  // ==========================================================================
  // reset values
  localparam logic [31:0] DCIT_PERIOD_RST = 32'hffff_ffff;
  localparam logic [15:0] DCIT_PRESCALE_RST = 16'h0000;
  localparam logic [1:0] DCIT_SRC_RST = 2'h0;
  localparam logic DCIT_RUN_RST = 1'b1;
  localparam logic DCIT_MASK_RST = 1'b0;
  localparam logic [31:0] DCIT_UNMAPPED_DATA = 32'h0000_0000;

  // clock source choices
  typedef enum logic [1:0] {
    DCIT_SRC_SYSTEM = 2'h0,
    DCIT_SRC_INTOSC_ONE = 2'h1,
    DCIT_SRC_INTOSC_TWO = 2'h2,
    DCIT_SRC_CRYSTAL = 2'h3
  } dcit_src_t;

  // avalon request carrier
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } dcit_req_t;
endpackage

// file: design/dcit_edge_sync.sv
// two flop synchroniser plus rising edge detect for an oscillator tick source
// assumes the oscillator is slower than half of clk_in
`timescale 1ns/100ps
module dcit_edge_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // asynchronous level in, single cycle tick out
  input wire logic async_in,
  output logic rise_out
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // ==========================================================================
  // first flop feeds only the second flop
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      rise_out <= sync_reg & ~last_reg;
    end
  end
endmodule // dcit_edge_sync

// file: design/dcit_timer.sv
// down counting interval timer with avalon-mm register port
// assumes the three oscillator sources are slow free running clocks, sampled as data
// assumes the bus master holds each request until it sees waitrequest low
// oscillators must run below half of clk_in or their ticks are lost
`timescale 1ns/100ps
module dcit_timer #(
  // prescaler width; divide value and live count share one 32-bit word
  parameter int PRESCALE_W = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // oscillator tick sources
  input wire logic internal_oscillator_one_in,
  input wire logic internal_oscillator_two_in,
  input wire logic crystal_oscillator_clock_in,
  // interrupt outputs
  output logic timer_irq_pulse_out,
  output logic timer_irq_level_out
);
  import dcit_pkg::*;

  // ==========================================================================
  // elaboration check: each prescale field must fit in half a register word
  if (PRESCALE_W < 1 || PRESCALE_W > 16) begin : g_prescale_w_check
    $error("PRESCALE_W must lie between 1 and 16");
  end

  logic [31:0] timer_count_value_reg;
  logic [31:0] timer_period_value_reg;
  logic [PRESCALE_W-1:0] prescale_div_reg;
  logic [PRESCALE_W-1:0] tick_prescale_counter_reg;
  logic [1:0] src_sel_reg;
  logic run_reg;
  logic reload_req_reg;
  logic ovf_reg;
  logic mask_reg;
  logic ack_reg;
  logic osc1_tick;
  logic osc2_tick;
  logic crystal_oscillator_clock_tick;
  logic src_tick;
  logic prescale_zero;
  logic count_tick;
  logic at_zero;
  logic expire;
  logic [31:0] timer_count_value_next;
  logic wr_hit;
  logic rd_hit;
  logic ctrl_wr;
  logic reload_set;
  logic ovf_clr;
  dcit_req_t req;

  // ==========================================================================
  // helpers
  // true when an accepted access targets the given offset
  function automatic logic reg_hit(input logic hit, input logic [3:0] adr, input logic [3:0] target);
    return hit && (adr == target);
  endfunction

  // widen a prescale field into its 16-bit half of the register word
  function automatic logic [15:0] prescale_field(input logic [PRESCALE_W-1:0] f);
    return 16'(f);
  endfunction

  // ==========================================================================
  // bus side
  assign req = '{address: avs_address_in, read: avs_read_in, write: avs_write_in,
                 writedata: avs_writedata_in};

  // one wait cycle: the request is taken on the edge where waitrequest is low
  // waitrequest is a flop of its own, so the port sees no gate after the ack flop
  // back to back requests each get their own wait cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_reg <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      ack_reg <= (req.read | req.write) & ~ack_reg;
      avs_waitrequest_out <= ~((req.read | req.write) & ~ack_reg);
    end
  end

  // accepted writes, the first-cycle read capture and the control write decodes that several registers use
  assign wr_hit = req.write & ack_reg;
  assign rd_hit = req.read & ~ack_reg;
  assign ctrl_wr = reg_hit(wr_hit, req.address, DCIT_OFS_CTRL);
  assign reload_set = ctrl_wr & req.writedata[DCIT_CTRL_RELOAD_BIT];
  assign ovf_clr = ctrl_wr & req.writedata[DCIT_CTRL_OVF_BIT];

  // read data registered so it stands at the accepting edge
  function automatic logic [31:0] read_mux(input logic [3:0] adr);
    logic [31:0] d;
    d = DCIT_UNMAPPED_DATA;
    case (adr)
      DCIT_OFS_COUNT: d = timer_count_value_reg;
      DCIT_OFS_PERIOD: d = timer_period_value_reg;
      DCIT_OFS_CTRL: begin
        d[DCIT_CTRL_RUN_BIT] = run_reg;
        d[DCIT_CTRL_RELOAD_BIT] = reload_req_reg;
        d[DCIT_CTRL_SRC_LSB +: 2] = src_sel_reg;
        d[DCIT_CTRL_OVF_BIT] = ovf_reg;
        d[DCIT_CTRL_MASK_BIT] = mask_reg;
      end
      DCIT_OFS_PRESCALE: d = {prescale_field(tick_prescale_counter_reg), prescale_field(prescale_div_reg)};
      default: d = DCIT_UNMAPPED_DATA;
    endcase
    return d;
  endfunction

  // read data is captured on the first request cycle and holds until the next read
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= DCIT_UNMAPPED_DATA;
    end else if (rd_hit) begin
      avs_readdata_out <= read_mux(req.address);
    end
  end

  // ==========================================================================
  // configuration registers, one process per field group
  // a new period is used at the next reload or wrap, not mid count
  // period register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_period_value_reg <= DCIT_PERIOD_RST;
    end else if (reg_hit(wr_hit, req.address, DCIT_OFS_PERIOD)) begin
      timer_period_value_reg <= req.writedata;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prescale_div_reg <= PRESCALE_W'(DCIT_PRESCALE_RST);
    end else if (reg_hit(wr_hit, req.address, DCIT_OFS_PRESCALE)) begin
      prescale_div_reg <= req.writedata[PRESCALE_W-1:0];
    end
  end

  // a source change mid count keeps the partial prescale count
  // source select
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      src_sel_reg <= DCIT_SRC_RST;
    end else if (ctrl_wr) begin
      src_sel_reg <= req.writedata[DCIT_CTRL_SRC_LSB +: 2];
    end
  end

  // run enable and interrupt mask, both written with the control word
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run_reg <= DCIT_RUN_RST;
      mask_reg <= DCIT_MASK_RST;
    end else if (ctrl_wr) begin
      run_reg <= req.writedata[DCIT_CTRL_RUN_BIT];
      mask_reg <= req.writedata[DCIT_CTRL_MASK_BIT];
    end
  end

  // ==========================================================================
  // tick sources
  // each oscillator passes two synchroniser flops and an edge flop, so a tick trails its edge by three clocks
  dcit_edge_sync u_osc1 (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in(internal_oscillator_one_in),
    .rise_out(osc1_tick)
  );
  dcit_edge_sync u_osc2 (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in(internal_oscillator_two_in),
    .rise_out(osc2_tick)
  );
  dcit_edge_sync u_crystal_oscillator_clock (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in(crystal_oscillator_clock_in),
    .rise_out(crystal_oscillator_clock_tick)
  );

  // four way tick select
  // every code is decoded, so the default branch only guards unknowns
  always_comb begin
    case (dcit_src_t'(src_sel_reg))
      DCIT_SRC_SYSTEM: src_tick = 1'b1;
      DCIT_SRC_INTOSC_ONE: src_tick = osc1_tick;
      DCIT_SRC_INTOSC_TWO: src_tick = osc2_tick;
      DCIT_SRC_CRYSTAL: src_tick = crystal_oscillator_clock_tick;
      default: src_tick = 1'b0;
    endcase
  end

  // prescaler counts source ticks
  // divide value P gives one count tick per P+1 source ticks
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_prescale_counter_reg <= PRESCALE_W'(DCIT_PRESCALE_RST);
    end else if (reload_req_reg) begin
      tick_prescale_counter_reg <= prescale_div_reg;
    end else if (run_reg && src_tick) begin
      if (prescale_zero) begin
        tick_prescale_counter_reg <= prescale_div_reg;
      end else begin
        tick_prescale_counter_reg <= tick_prescale_counter_reg - PRESCALE_W'(1);
      end
    end
  end

  // a reload cycle swallows any tick that lands on it
  assign prescale_zero = (tick_prescale_counter_reg == '0);
  assign count_tick = run_reg & src_tick & prescale_zero & ~reload_req_reg;
  assign at_zero = (timer_count_value_reg == 32'h0000_0000);
  assign expire = count_tick & at_zero;

  // ==========================================================================
  // reload request: set by software, cleared once the load is done
  // the request comes up out of reset so the reset period loads before any tick
  // reload request
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reload_req_reg <= 1'b1; // load the period right after reset
    end else begin
      reload_req_reg <= reload_set;
    end
  end

  // next count: reload and wrap both take the period, a tick takes one off
  // a reload wins over a tick in the same cycle
  always_comb begin
    timer_count_value_next = timer_count_value_reg;
    if (reload_req_reg) begin
      timer_count_value_next = timer_period_value_reg;
    end else if (count_tick) begin
      if (at_zero) begin
        timer_count_value_next = timer_period_value_reg;
      end else begin
        timer_count_value_next = timer_count_value_reg - 32'h0000_0001;
      end
    end
  end

  // main counter; while run is low it changes only on a reload
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_count_value_reg <= 32'h0000_0000;
    end else begin
      timer_count_value_reg <= timer_count_value_next;
    end
  end

  // ==========================================================================
  // overflow flag; a new expiry beats a same cycle write-one clear,
  // so software never misses an event it has not yet seen
  // overflow flag set
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ovf_reg <= 1'b0;
    end else if (expire) begin
      ovf_reg <= 1'b1;
    end else if (ovf_clr) begin
      ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_irq_pulse_out <= 1'b0;
    end else begin
      timer_irq_pulse_out <= expire;
    end
  end

  // level interrupt: masked flag, plus the expiry so it rises with the pulse
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_irq_level_out <= 1'b0;
    end else begin
      timer_irq_level_out <= mask_reg & (ovf_reg | expire);
    end
  end
endmodule // dcit_timer

// file: verification/dcit_chk.sv
// checker: bus handshake and interrupt outputs of the timer
// assumes one clock domain, bound onto dcit_timer
`timescale 1ns/100ps
module dcit_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // bus and interrupts
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic timer_irq_pulse_out,
  input wire logic timer_irq_level_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================================================
  // handshake
  wait_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("no answer after request");
  wait_once_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer longer than one cycle");
  wait_idle_a: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
    else $error("answer without request");
  data_hold_a: assert property (!avs_read_in |=> $stable(avs_readdata_out))
    else $error("read data moved without read");
  // ==========================================================================
  // interrupts: single pulse, level only raised by an expiry or a bus write
  pulse_single_a: assert property (timer_irq_pulse_out |=> !timer_irq_pulse_out)
    else $error("pulse longer than one cycle");
  level_rise_a: assert property ($rose(timer_irq_level_out) |-> timer_irq_pulse_out || $past(avs_write_in, 2))
    else $error("level rose without pulse");
  level_fall_a: assert property ($fell(timer_irq_level_out) |-> $past(avs_write_in) || $past(avs_write_in, 2))
    else $error("level fell without write");
endmodule // dcit_chk

bind dcit_timer dcit_chk i_dcit_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .timer_irq_pulse_out(timer_irq_pulse_out), .timer_irq_level_out(timer_irq_level_out));

// file: verification/dcit_osc_model.sv
// far side model: three free running slow oscillators
// assumes a 100 ns main clock whose rising edges sit at odd 50 ns points
`timescale 1ns/100ps
module dcit_osc_model #(parameter int HALF_ONE = 400, parameter int HALF_TWO = 600, parameter int HALF_CRYSTAL_OSCILLATOR_CLOCK = 800) (
  // oscillator outputs
  output logic osc_one_out,
  output logic osc_two_out,
  output logic crystal_oscillator_clock_out
);
  // whole-cycle periods keep tick spacing exact, so intervals can be checked to the cycle
  initial begin
    osc_one_out = 1'b0;
    osc_two_out = 1'b0;
    crystal_oscillator_clock_out = 1'b0;
  end
  always #HALF_ONE osc_one_out = !osc_one_out;
  always #HALF_TWO osc_two_out = !osc_two_out;
  always #HALF_CRYSTAL_OSCILLATOR_CLOCK crystal_oscillator_clock_out = !crystal_oscillator_clock_out;
endmodule // dcit_osc_model

// file: verification/tb.sv
// testbench: register access, interval timing per source, overflow and mask
// assumes dcit_timer, the oscillator model and the bound checker
`timescale 1ns/100ps
module tb;
  import dcit_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  dcit_req_t req = '0;
  logic [31:0] avs_readdata_out, cyc = '0, last = '0, v, p;
  logic avs_waitrequest_out, timer_irq_pulse_out, timer_irq_level_out, o1, o2, ox;
  logic [31:0] rq[$], iq[$];
  int mismatches = 0, num_checks = 0, seed = 42526, mul[4] = '{1, 8, 12, 16};
  always #50 clk_in = !clk_in;
  dcit_osc_model i_dcit_osc_model (.osc_one_out(o1), .osc_two_out(o2), .crystal_oscillator_clock_out(ox));
  dcit_timer i_dcit_timer (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(req.address),
    .avs_read_in(req.read), .avs_write_in(req.write), .avs_writedata_in(req.writedata),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .internal_oscillator_one_in(o1), .internal_oscillator_two_in(o2), .crystal_oscillator_clock_in(ox),
    .timer_irq_pulse_out(timer_irq_pulse_out), .timer_irq_level_out(timer_irq_level_out));
  // ==========================================================================
  // compare and close
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // avalon master: hold until waitrequest sampled low, then release and let an edge pass
  task automatic bus(input logic [3:0] a, input logic r, input logic [31:0] d);
    req <= '{a, r, !r, d};
    @(posedge clk_in iff avs_waitrequest_out === 1'b0);
    req <= '0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(a, 1'b1, '0);
  endtask
  // ==========================================================================
  // monitor: read data and pulse spacing against the oldest note
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (req.read && avs_waitrequest_out === 1'b0) check("readdata", avs_readdata_out, rq.pop_front());
    if (timer_irq_pulse_out === 1'b1) begin
      if (iq.size() > 0) check("interval", cyc - last, iq.pop_front());
      last = cyc;
    end
  end
  // watchdog sized well above the longest interval run
  initial begin
    #(30000 * 100);
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    // reset values and an unaligned hole
    rd(DCIT_OFS_PERIOD, DCIT_PERIOD_RST);
    rd(DCIT_OFS_CTRL, 32'h0000_0001);
    rd(DCIT_OFS_PRESCALE, 32'h0000_0000);
    rd(4'h1, DCIT_UNMAPPED_DATA);
    $display("test reset done");
    // every source, random period, prescale on the system clock
    for (int s = 0; s < 4; s++) begin
      v = 32'h0000_0004 + ($unsigned($random(seed)) % 32);
      p = (s == 0) ? $unsigned($random(seed)) % 4 : 32'h0000_0000;
      bus(DCIT_OFS_PERIOD, 1'b0, v);
      bus(DCIT_OFS_PRESCALE, 1'b0, p);
      bus(DCIT_OFS_CTRL, 1'b0, 32'h0000_0203 | (s << DCIT_CTRL_SRC_LSB));
      @(posedge clk_in iff timer_irq_pulse_out === 1'b1);
      // one edge on, so the monitor has taken this pulse as its start point
      @(posedge clk_in);
      // interval (v+1)*(p+1) ticks, periodic after reload
      repeat (2) iq.push_back((v + 1) * (p + 1) * mul[s]);
      repeat (2) @(posedge clk_in iff timer_irq_pulse_out === 1'b1);
      bus(DCIT_OFS_CTRL, 1'b0, 32'h0000_0200);
      $display("test source %0d done", s);
    end
    // overflow flag sticky, mask gates level, write one clears
    rd(DCIT_OFS_CTRL, 32'h0000_0300);
    check("level", {31'h0, timer_irq_level_out}, 32'h1);
    bus(DCIT_OFS_CTRL, 1'b0, 32'h0000_0000);
    rd(DCIT_OFS_CTRL, 32'h0000_0100);
    check("level", {31'h0, timer_irq_level_out}, 32'h0);
    bus(DCIT_OFS_CTRL, 1'b0, 32'h0000_0300);
    rd(DCIT_OFS_CTRL, 32'h0000_0200);
    check("level", {31'h0, timer_irq_level_out}, 32'h0);
    // reload while stopped, count read only
    bus(DCIT_OFS_CTRL, 1'b0, 32'h0000_0002);
    rd(DCIT_OFS_COUNT, v);
    bus(DCIT_OFS_COUNT, 1'b0, 32'h0000_1234);
    rd(DCIT_OFS_COUNT, v);
    $display("test overflow and reload done");
    end_sim();
  end
endmodule // tb
